//--- src/ppp_port.sv
// Parallel programming port: latches, command decode, memories and ready/busy timing.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] Ready/busy low while programming, high otherwise.
// [R02] Action code selects address, data, command, idle.
// [R03] Byte select chooses low or high address.
// [R04] Strobes execute the last loaded command.
// [R05] Bits 4,1,3 write, read, signature; bit0 array.
// [R06] Bit 6 writes fuses from D5, D0.
// [R07] Bit 5 writes lock bits from D1, D0.
// [R08] Bit 2 reads locks D7, D6, fuses D5, D0.
// [R09] Programmer holds reset, byte select low first.
// [R10] Byte select stable 100 ns after entry.
// [R11] Erase clears arrays, then locks; fuses kept.
// [R12] Programmer erases before programming flash.
// [R13] Erase command 80h, write pulse enables lock erase.
// [R14] Ready/busy unchanged during chip erase.
// [R15] Flash program command is 10h.
// [R16] Flash high address limited to 07h.
// [R17] Data byte loaded with action code 01.
// [R18] Write with byte select low programs low byte.
// [R19] Write with byte select high programs high byte.
// [R20] Command and address kept across bytes.
// [R21] Byte programming lasts 0.5 to 0.9 ms.
// [R22] One holding register updated per latch pulse.
// [R23] Bus driven only on output enable with read.
module ppp_port
	import ppp_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_MIN,
	parameter int unsigned ERASE_WAIT = ERASE_CYCLES,
	parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identification value.
	parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary identification value.
	parameter logic [7:0] SIG_BYTE2 = 8'h66 // Arbitrary identification value.
) (
	input wire logic core_clk_i, // 20 MHz system clock.
	input wire logic rst_n_i, // Asynchronous active-low reset.
	input wire logic prog_mode_i, // High-voltage entry level on reset pin.
	input wire logic action_code_bit0_i, // Action code bit 0.
	input wire logic action_code_bit1_i, // Action code bit 1.
	input wire logic byte_select_i, // Byte select.
	input wire logic latch_strobe_pin_i, // Positive pulse latches a byte.
	input wire logic write_n_i, // Active-low write strobe.
	input wire logic out_en_n_i, // Active-low output enable.
	input wire logic [7:0] parallel_data_bus_i, // Bus level from the pins.
	output logic [7:0] parallel_data_bus_o, // Bus value driven out.
	output logic parallel_data_bus_oe_o, // High while driving the bus.
	output logic ready_busy_n_o, // Low while programming.
	output logic prog_active_o, // High when programming mode was entered.
	output logic serial_download_fuse_o, // Fuse level, 0 programmed.
	output logic short_startup_fuse_o // Fuse level, 0 programmed.
);

	// ************************************************************
	// Pin synchronisation
	// ************************************************************
	localparam int unsigned NPIN = 15;
	localparam int unsigned PROG_W = $clog2(PROG_CYCLES + 1);
	localparam int unsigned ERASE_W = $clog2(ERASE_WAIT + 1);
	localparam int unsigned HOLD_W = $clog2(ENTRY_HOLD_CYCLES + 2);

	typedef enum {ST_OFF, ST_ENTRY, ST_IDLE, ST_PROG, ST_ERASE, ST_FAIL} ppp_state_t;

	logic [NPIN-1:0] raw_w;
	logic [NPIN-1:0] syn_w;
	ppp_pins_t pin_w;
	logic mode_w;

	// The entry level goes in inverted, so the all-ones reset reads as no high voltage.
	assign raw_w = {~prog_mode_i, action_code_bit1_i, action_code_bit0_i, byte_select_i,
		latch_strobe_pin_i, write_n_i, out_en_n_i, parallel_data_bus_i};

	ppp_sync #(.WIDTH(NPIN)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(raw_w),
		.sync_o(syn_w)
	);

	assign mode_w = ~syn_w[14];
	assign pin_w = syn_w[13:0];

	// ************************************************************
	// State and storage
	// ************************************************************
	ppp_state_t state_q;
	logic latch_prev_q;
	logic write_prev_q;
	logic [7:0] cmd_q;
	logic [7:0] addr_lo_q;
	logic [7:0] addr_hi_q;
	logic [7:0] data_q;
	logic [PROG_W-1:0] prog_cnt_q;
	logic [ERASE_W-1:0] erase_cnt_q;
	logic [HOLD_W-1:0] hold_cnt_q;
	logic entry_bs_q;
	logic lock_erase_q;
	logic erase_ptr_done_q;
	logic [10:0] erase_ptr_q;
	ppp_cfg_t cfg_q;
	logic wr_hi_q;
	logic [7:0] bus_q;
	logic bus_oe_q;
	logic ready_q;
	logic prog_active_q;
	logic [7:0] flash_lo_mem [FLASH_WORDS];
	logic [7:0] flash_hi_mem [FLASH_WORDS];
	logic [7:0] eeprom_mem [EEPROM_BYTES];

	// ************************************************************
	// Strobe decode
	// ************************************************************
	logic latch_rise_w;
	logic write_fall_w;
	logic is_idle_w;
	logic [10:0] flash_addr_w;
	logic lock_ok_w;
	logic [7:0] status_w;
	logic read_cmd_w;
	logic [7:0] rd_data_w;

	// Edges of the filtered strobes.
	assign latch_rise_w = pin_w.latch_strobe & ~latch_prev_q; // R22
	assign write_fall_w = ~pin_w.write_n & write_prev_q; // R04
	assign is_idle_w = (state_q == ST_IDLE);
	assign flash_addr_w = {addr_hi_q[2:0], addr_lo_q}; // R16
	// Lock bit one programmed blocks further array programming.
	assign lock_ok_w = cfg_q.lock_bit_one;
	// Fuse and lock status byte.
	assign status_w = {cfg_q.lock_bit_one, cfg_q.lock_bit_two, cfg_q.serial_download_fuse,
		4'hf, cfg_q.short_startup_fuse}; // R08
	assign read_cmd_w = cmd_q[CMD_MEM_RD_BIT] | cmd_q[CMD_SIG_RD_BIT] | cmd_q[CMD_FL_RD_BIT];
	// Read data selection by command bits and byte select.
	assign rd_data_w = cmd_q[CMD_FL_RD_BIT] ? status_w :
		cmd_q[CMD_SIG_RD_BIT] ? ((addr_lo_q == 8'h00) ? SIG_BYTE0 :
			(addr_lo_q == 8'h01) ? SIG_BYTE1 : SIG_BYTE2) :
		cmd_q[CMD_EEPROM_BIT] ? eeprom_mem[addr_lo_q] :
		pin_w.byte_select ? flash_hi_mem[flash_addr_w] : flash_lo_mem[flash_addr_w]; // R05

	// ************************************************************
	// Control sequencer
	// ************************************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_OFF;
			latch_prev_q <= 1'b1;
			write_prev_q <= 1'b1;
			cmd_q <= CMD_RESET;
			addr_lo_q <= 8'h00;
			addr_hi_q <= 8'h00;
			data_q <= ERASED_BYTE;
			prog_cnt_q <= '0;
			erase_cnt_q <= '0;
			hold_cnt_q <= '0;
			entry_bs_q <= 1'b0;
			lock_erase_q <= 1'b0;
			erase_ptr_q <= 11'h000;
			erase_ptr_done_q <= 1'b0;
			cfg_q <= {1'b1, 1'b1, FUSE_SERIAL_RESET, FUSE_STARTUP_RESET};
			wr_hi_q <= 1'b0;
			ready_q <= 1'b1;
		end else begin
			latch_prev_q <= pin_w.latch_strobe;
			write_prev_q <= pin_w.write_n;
			case (state_q)
				ST_OFF: begin
					if (mode_w) begin
						state_q <= ST_ENTRY;
						entry_bs_q <= pin_w.byte_select;
						hold_cnt_q <= '0;
					end
				end
				ST_ENTRY: begin
					// Byte select must not move during the entry window.
					if (!mode_w || pin_w.byte_select != entry_bs_q) begin
						state_q <= ST_FAIL; // R10
					end else if (hold_cnt_q == HOLD_W'(ENTRY_HOLD_CYCLES)) begin
						state_q <= ST_IDLE;
					end else begin
						hold_cnt_q <= hold_cnt_q + 1'b1;
					end
				end
				ST_IDLE: begin
					if (!mode_w) begin
						state_q <= ST_OFF;
					end else if (latch_rise_w) begin
						// At most one holding register per pulse; action code 3 loads none.
						if (pin_w.action == ACT_ADDR && !pin_w.byte_select) begin
							addr_lo_q <= pin_w.data; // R03
						end else if (pin_w.action == ACT_ADDR) begin
							addr_hi_q <= pin_w.data; // R03
						end else if (pin_w.action == ACT_DATA) begin
							data_q <= pin_w.data; // R17
						end else if (pin_w.action == ACT_CMD) begin
							cmd_q <= pin_w.data; // R02
							if (pin_w.data[CMD_ERASE_BIT]) begin
								state_q <= ST_ERASE; // R13
								erase_cnt_q <= '0;
								erase_ptr_q <= 11'h000;
								erase_ptr_done_q <= 1'b0;
								lock_erase_q <= 1'b0;
							end
						end
					end else if (write_fall_w) begin
						// Command and address stay loaded for the next byte.
						if (cmd_q[CMD_FUSE_WR_BIT]) begin
							cfg_q.serial_download_fuse <= data_q[FUSE_SERIAL_POS]; // R06
							cfg_q.short_startup_fuse <= data_q[FUSE_STARTUP_POS]; // R06
						end
						if (cmd_q[CMD_LOCK_WR_BIT]) begin
							cfg_q.lock_bit_one <= cfg_q.lock_bit_one & data_q[LOCK_ONE_WR_POS]; // R07
							cfg_q.lock_bit_two <= cfg_q.lock_bit_two & data_q[LOCK_TWO_WR_POS]; // R07
						end
						if (cmd_q[CMD_FUSE_WR_BIT] | cmd_q[CMD_LOCK_WR_BIT] | cmd_q[CMD_MEM_WR_BIT]) begin
							state_q <= ST_PROG; // R20
							wr_hi_q <= pin_w.byte_select; // R18 R19
							prog_cnt_q <= '0;
							ready_q <= 1'b0; // R01
						end
					end
				end
				ST_PROG: begin
					if (prog_cnt_q == PROG_W'(PROG_CYCLES - 1)) begin
						state_q <= ST_IDLE;
						ready_q <= 1'b1; // R21
					end else begin
						prog_cnt_q <= prog_cnt_q + 1'b1;
					end
				end
				ST_ERASE: begin
					// Ready/busy is not touched here.
					if (write_fall_w) begin
						lock_erase_q <= 1'b1; // R13
					end
					if (!erase_ptr_done_q) begin
						erase_ptr_q <= erase_ptr_q + 1'b1;
						erase_ptr_done_q <= (erase_ptr_q == 11'h7ff);
					end
					if (erase_cnt_q == ERASE_W'(ERASE_WAIT - 1)) begin
						state_q <= ST_IDLE; // R14
						if (lock_erase_q && erase_ptr_done_q) begin
							cfg_q.lock_bit_one <= 1'b1; // R11
							cfg_q.lock_bit_two <= 1'b1; // R11
						end
					end else begin
						erase_cnt_q <= erase_cnt_q + 1'b1;
					end
				end
				default: state_q <= mode_w ? state_q : ST_OFF; // R10 Failed entry waits for no voltage.
			endcase
		end
	end

	// ************************************************************
	// Memory arrays
	// ************************************************************
	logic prog_wr_w;
	assign prog_wr_w = (state_q == ST_PROG) && (prog_cnt_q == '0) && cmd_q[CMD_MEM_WR_BIT]
		&& lock_ok_w; // R15

	// Byte writes at the start of programming, and erase sweeps of both arrays.
	always_ff @(posedge core_clk_i) begin
		if (state_q == ST_ERASE && !erase_ptr_done_q) begin
			flash_lo_mem[erase_ptr_q] <= ERASED_BYTE; // R11
			flash_hi_mem[erase_ptr_q] <= ERASED_BYTE; // R11
			eeprom_mem[erase_ptr_q[7:0]] <= ERASED_BYTE; // R11
		end else if (prog_wr_w && cmd_q[CMD_EEPROM_BIT]) begin
			eeprom_mem[addr_lo_q] <= data_q; // R05
		end else if (prog_wr_w && wr_hi_q) begin
			flash_hi_mem[flash_addr_w] <= data_q; // R19
		end else if (prog_wr_w) begin
			flash_lo_mem[flash_addr_w] <= data_q; // R18
		end
	end

	// ************************************************************
	// Bus drive and outputs
	// ************************************************************
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_q <= 8'h00;
			bus_oe_q <= 1'b0;
			prog_active_q <= 1'b0;
		end else begin
			bus_oe_q <= is_idle_w && !pin_w.out_en_n && read_cmd_w; // R23
			bus_q <= rd_data_w;
			prog_active_q <= is_idle_w || (state_q == ST_PROG) || (state_q == ST_ERASE);
		end
	end

	assign parallel_data_bus_o = bus_q;
	assign parallel_data_bus_oe_o = bus_oe_q;
	assign ready_busy_n_o = ready_q;
	assign prog_active_o = prog_active_q;
	assign serial_download_fuse_o = cfg_q.serial_download_fuse;
	assign short_startup_fuse_o = cfg_q.short_startup_fuse;

endmodule // ppp_port

//--- src/ppp_pkg.sv
// Package for the parallel memory programming port: constants, types and timing.
package ppp_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CLK_FREQ_HZ = 20_000_000;
	localparam int unsigned CLK_PERIOD_NS = 50;
	// Least byte programming time in microseconds, rounded up to cycles.
	localparam int unsigned PROG_TIME_MIN_US = 500;
	// Longest byte programming time in microseconds, rounded down to cycles.
	localparam int unsigned PROG_TIME_MAX_US = 900;
	localparam int unsigned PROG_CYCLES_MIN = (PROG_TIME_MIN_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int unsigned PROG_CYCLES_MAX = (PROG_TIME_MAX_US * 1000) / CLK_PERIOD_NS;
	// Chip erase wait in microseconds.
	localparam int unsigned ERASE_TIME_US = 10_000;
	localparam int unsigned ERASE_CYCLES = (ERASE_TIME_US * 1000) / CLK_PERIOD_NS;
	// Byte select stable window after entry, in nanoseconds.
	localparam int unsigned ENTRY_HOLD_NS = 100;
	localparam int unsigned ENTRY_HOLD_CYCLES = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// ************************************************************
	// Action codes and command bits
	// ************************************************************
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam int unsigned CMD_ERASE_BIT = 7;
	localparam int unsigned CMD_FUSE_WR_BIT = 6;
	localparam int unsigned CMD_LOCK_WR_BIT = 5;
	localparam int unsigned CMD_MEM_WR_BIT = 4;
	localparam int unsigned CMD_SIG_RD_BIT = 3;
	localparam int unsigned CMD_FL_RD_BIT = 2;
	localparam int unsigned CMD_MEM_RD_BIT = 1;
	localparam int unsigned CMD_EEPROM_BIT = 0;

	// ************************************************************
	// Data byte field positions
	// ************************************************************
	localparam int unsigned FUSE_SERIAL_POS = 5;
	localparam int unsigned FUSE_STARTUP_POS = 0;
	localparam int unsigned LOCK_ONE_WR_POS = 1;
	localparam int unsigned LOCK_TWO_WR_POS = 0;
	localparam int unsigned LOCK_ONE_RD_POS = 7;
	localparam int unsigned LOCK_TWO_RD_POS = 6;

	// ************************************************************
	// Reset values and sizes
	// ************************************************************
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic FUSE_SERIAL_RESET = 1'b0;
	localparam logic FUSE_STARTUP_RESET = 1'b1;
	localparam int unsigned FLASH_WORDS = 2048;
	localparam int unsigned EEPROM_BYTES = 256;

	// Inputs of the port as the pins deliver them.
	typedef struct packed {
		logic [1:0] action;
		logic byte_select;
		logic latch_strobe;
		logic write_n;
		logic out_en_n;
		logic [7:0] data;
	} ppp_pins_t;

	// Non-volatile configuration bits, 0 meaning programmed.
	typedef struct packed {
		logic lock_bit_one;
		logic lock_bit_two;
		logic serial_download_fuse;
		logic short_startup_fuse;
	} ppp_cfg_t;

endpackage

//--- src/ppp_sync.sv
// Three-stage synchroniser with agreement filter for a bundle of pin inputs.
`timescale 1ns/1ps
module ppp_sync #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic core_clk_i, // System clock.
	input wire logic rst_n_i, // Asynchronous active-low reset.
	input wire logic [WIDTH-1:0] async_i, // Raw pin levels.
	output logic [WIDTH-1:0] sync_o // Filtered levels.
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;

	// The first stage feeds only the second; a change counts once stages two and three agree.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					s1_q[g] <= 1'b1;
					s2_q[g] <= 1'b1;
					s3_q[g] <= 1'b1;
					out_q[g] <= 1'b1;
				end else begin
					s1_q[g] <= async_i[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					if (s2_q[g] == s3_q[g]) begin
						out_q[g] <= s3_q[g];
					end
				end
			end
		end
	endgenerate

	assign sync_o = out_q;

endmodule // ppp_sync

//--- verif/ppp_prog_model.sv
// Behavioural parallel programmer that drives the port pins.
`timescale 1ns/1ps
module ppp_prog_model #(
	parameter int TMO = 200
) (
	input wire logic clk_i, // Bench clock.
	input wire logic [7:0] bus_i, // Bus value from the port.
	input wire logic oe_i, // Port drives the bus.
	input wire logic ready_busy_n_i, // Ready/busy from the port.
	output logic [7:0] bus_o, // Bus level seen by the port.
	output logic [1:0] action_o, // Action code.
	output logic byte_select_o, // Byte select.
	output logic latch_strobe_pin_o, // Latch strobe.
	output logic write_n_o, // Write strobe.
	output logic out_en_n_o, // Output enable.
	output logic prog_mode_o // High voltage on the reset pin.
);
	logic [7:0] drv_q;
	logic rel_q;
	// A released bus shows the inverse of the last value, so stale data never matches.
	assign bus_o = oe_i ? bus_i : (rel_q ? ~drv_q : drv_q);
	// All pins idle from time zero, byte select low for entry.
	initial begin
		drv_q = 8'h00;
		rel_q = 1'b0;
		action_o = 2'h3;
		byte_select_o = 1'b0;
		latch_strobe_pin_o = 1'b0;
		write_n_o = 1'b1;
		out_en_n_o = 1'b1;
		prog_mode_o = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Raises the high voltage and keeps byte select still afterwards.
	task automatic enter();
		step(4);
		prog_mode_o = 1'b1;
		step(20);
	endtask
	// Raises the high voltage, then moves byte select inside the hold window.
	task automatic enter_bad();
		step(4);
		prog_mode_o = 1'b1;
		step(1);
		byte_select_o = 1'b1;
		step(20);
	endtask
	// Takes the high voltage away again and parks byte select low.
	task automatic leave();
		prog_mode_o = 1'b0;
		byte_select_o = 1'b0;
		step(20);
	endtask
	// Loads one byte with a positive latch pulse.
	task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
		action_o = a;
		byte_select_o = b;
		drv_q = d;
		step(3);
		latch_strobe_pin_o = 1'b1;
		step(12);
		latch_strobe_pin_o = 1'b0;
		step(12);
	endtask
	// Gives a write pulse, notes any busy, then waits for ready.
	task automatic wr(input logic b, output logic busy);
		byte_select_o = b;
		busy = 1'b0;
		step(3);
		write_n_o = 1'b0;
		repeat (12) begin
			@(negedge clk_i);
			busy = busy | ~ready_busy_n_i;
		end
		write_n_o = 1'b1;
		for (int i = 0; i < TMO && ready_busy_n_i !== 1'b1; i++) @(negedge clk_i);
		step(4);
	endtask
	// Releases the bus, pulses output enable and samples the bus.
	task automatic rd(input logic b, output logic [7:0] d, output logic en);
		byte_select_o = b;
		rel_q = 1'b1;
		step(3);
		out_en_n_o = 1'b0;
		step(10);
		d = bus_i;
		en = oe_i;
		out_en_n_o = 1'b1;
		step(12);
		rel_q = 1'b0;
	endtask
endmodule // ppp_prog_model

//--- verif/ppp_port_checker.sv
// Assertions on the ports of the parallel programming port.
`timescale 1ns/1ps
module ppp_port_checker
	import ppp_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_MIN
) (
	input wire logic core_clk_i, // Clock.
	input wire logic rst_n_i, // Reset, active low.
	input wire logic prog_mode_i, // Entry level.
	input wire logic byte_select_i, // Byte select.
	input wire logic write_n_i, // Write strobe.
	input wire logic out_en_n_i, // Output enable.
	input wire logic parallel_data_bus_oe_o, // Bus drive enable.
	input wire logic ready_busy_n_o, // Ready/busy.
	input wire logic prog_active_o, // Mode entered.
	input wire logic serial_download_fuse_o, // Fuse.
	input wire logic short_startup_fuse_o // Fuse.
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	int unsigned low_q;
	int unsigned since_wr_q;
	// Counts busy cycles and cycles since the last write strobe.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_q <= 32'h0;
			since_wr_q <= 32'hffff;
		end else begin
			low_q <= ready_busy_n_o ? 32'h0 : low_q + 32'h1;
			since_wr_q <= !write_n_i ? 32'h0 : since_wr_q + {31'h0, since_wr_q < 32'hffff};
		end
	end
	sequence s_wr_seen;
		!$past(write_n_i, 4) && since_wr_q < 8;
	endsequence
	sequence s_busy_run;
		!ready_busy_n_o [*8];
	endsequence
	property p_entry;
		$rose(prog_active_o) |-> $past(prog_mode_i, 6) && $past(byte_select_i, 3) == $past(byte_select_i, 6);
	endproperty
	property p_rdy_idle;
		!prog_active_o |-> ready_busy_n_o;
	endproperty
	property p_busy_cause;
		$fell(ready_busy_n_o) |-> s_wr_seen;
	endproperty
	property p_busy_min;
		$fell(ready_busy_n_o) |-> s_busy_run;
	endproperty
	property p_busy_len;
		$rose(ready_busy_n_o) |-> low_q == PROG_CYCLES;
	endproperty
	property p_oe_cause;
		$rose(parallel_data_bus_oe_o) |-> !$past(out_en_n_i, 4) && prog_active_o;
	endproperty
	property p_oe_release;
		$rose(out_en_n_i) |-> ##[1:8] !parallel_data_bus_oe_o;
	endproperty
	property p_oe_idle;
		!prog_active_o [*2] |-> !parallel_data_bus_oe_o;
	endproperty
	property p_fuse_cause;
		($changed(serial_download_fuse_o) || $changed(short_startup_fuse_o)) |-> since_wr_q < PROG_CYCLES + 40;
	endproperty
	a_entry: assert property (p_entry) else $error("entry without stable select");
	a_rdy_idle: assert property (p_rdy_idle) else $error("busy outside mode");
	a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	a_oe_cause: assert property (p_oe_cause) else $error("bus driven unasked");
	a_oe_release: assert property (p_oe_release) else $error("bus not released");
	a_oe_idle: assert property (p_oe_idle) else $error("bus driven outside mode");
	a_fuse_cause: assert property (p_fuse_cause) else $error("fuse moved alone");
endmodule // ppp_port_checker

bind ppp_port ppp_port_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.core_clk_i, .rst_n_i,
	.prog_mode_i, .byte_select_i, .write_n_i, .out_en_n_i, .parallel_data_bus_oe_o,
	.ready_busy_n_o, .prog_active_o, .serial_download_fuse_o, .short_startup_fuse_o);

//--- verif/tb.sv
// Self-checking bench for the parallel programming port.
`timescale 1ns/1ps
module tb
	import ppp_pkg::*;
;
	localparam logic [23:0] SIGS = 24'h332211; // Arbitrary identification values.
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic prog_mode_i, byte_select_i, latch_strobe_pin_i, write_n_i, out_en_n_i;
	logic [1:0] act;
	logic [7:0] parallel_data_bus_i, parallel_data_bus_o;
	logic parallel_data_bus_oe_o, ready_busy_n_o, prog_active_o;
	logic serial_download_fuse_o, short_startup_fuse_o;
	int n_fail = 0;
	int cmp_count = 0;
	ppp_port #(.PROG_CYCLES(20), .ERASE_WAIT(2100), .SIG_BYTE0(SIGS[7:0]),
		.SIG_BYTE1(SIGS[15:8]), .SIG_BYTE2(SIGS[23:16])) dut (
		.core_clk_i, .rst_n_i, .prog_mode_i, .action_code_bit0_i(act[0]),
		.action_code_bit1_i(act[1]), .byte_select_i, .latch_strobe_pin_i, .write_n_i,
		.out_en_n_i, .parallel_data_bus_i, .parallel_data_bus_o, .parallel_data_bus_oe_o,
		.ready_busy_n_o, .prog_active_o, .serial_download_fuse_o, .short_startup_fuse_o);
	ppp_prog_model #(.TMO(200)) prog (.clk_i(core_clk_i), .bus_i(parallel_data_bus_o),
		.oe_i(parallel_data_bus_oe_o), .ready_busy_n_i(ready_busy_n_o),
		.bus_o(parallel_data_bus_i), .action_o(act), .byte_select_o(byte_select_i),
		.latch_strobe_pin_o(latch_strobe_pin_i), .write_n_o(write_n_i),
		.out_en_n_o(out_en_n_i), .prog_mode_o(prog_mode_i));
	// Clock of 50 ns period.
	always #25 core_clk_i = ~core_clk_i;
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Reads one byte and checks that the bus is let go afterwards.
	task automatic rd_exp(input logic b, input logic [7:0] exp);
		logic [7:0] d;
		logic en;
		prog.rd(b, d, en);
		chk(d, exp);
		chk({7'h00, en}, 8'h01);
		chk({7'h00, parallel_data_bus_oe_o}, 8'h00);
	endtask
	task automatic wr_exp(input logic b, input logic exp);
		logic busy;
		prog.wr(b, busy);
		chk({7'h00, busy}, {7'h00, exp});
		chk({7'h00, ready_busy_n_o}, 8'h01);
	endtask
	task automatic t_erase();
		logic moved;
		moved = 1'b0;
		prog.load(ACT_CMD, 1'b0, 8'h80);
		wr_exp(1'b0, 1'b0);
		repeat (2300) begin
			@(negedge core_clk_i);
			moved = moved | ~ready_busy_n_o;
		end
		chk({7'h00, moved}, 8'h00);
	endtask
	task automatic t_entry();
		prog.enter_bad();
		chk({7'h00, prog_active_o}, 8'h00);
		prog.leave();
		prog.enter();
		chk({7'h00, prog_active_o}, 8'h01);
		chk({7'h00, ready_busy_n_o}, 8'h01);
	endtask
	task automatic t_fuse();
		prog.load(ACT_CMD, 1'b0, 8'h04);
		rd_exp(1'b1, 8'hdf);
		prog.load(ACT_CMD, 1'b0, 8'h40);
		prog.load(ACT_DATA, 1'b0, 8'hfe);
		wr_exp(1'b0, 1'b1);
		chk({6'h00, serial_download_fuse_o, short_startup_fuse_o}, 8'h02);
		prog.load(ACT_CMD, 1'b0, 8'h04);
		rd_exp(1'b1, 8'hfe);
	endtask
	task automatic t_flash();
		logic [7:0] d;
		logic en;
		t_erase();
		prog.load(ACT_CMD, 1'b0, 8'h10);
		prog.load(ACT_ADDR, 1'b0, 8'h34);
		prog.load(ACT_ADDR, 1'b1, 8'h07);
		prog.rd(1'b0, d, en);
		chk({7'h00, en}, 8'h00);
		prog.load(ACT_DATA, 1'b0, 8'ha5);
		wr_exp(1'b0, 1'b1);
		prog.load(ACT_DATA, 1'b0, 8'h5a);
		wr_exp(1'b1, 1'b1);
		prog.load(ACT_CMD, 1'b0, 8'h02);
		rd_exp(1'b0, 8'ha5);
		rd_exp(1'b1, 8'h5a);
		prog.load(ACT_ADDR, 1'b1, 8'h00);
		rd_exp(1'b0, 8'hff);
	endtask
	task automatic t_eeprom();
		prog.load(ACT_CMD, 1'b0, 8'h11);
		prog.load(ACT_ADDR, 1'b0, 8'h80);
		prog.load(ACT_DATA, 1'b0, 8'h3c);
		prog.load(2'h3, 1'b0, 8'h00);
		wr_exp(1'b0, 1'b1);
		prog.load(ACT_CMD, 1'b0, 8'h03);
		rd_exp(1'b0, 8'h3c);
		prog.load(ACT_CMD, 1'b0, 8'h02);
		rd_exp(1'b0, 8'hff);
	endtask
	task automatic t_sig();
		prog.load(ACT_CMD, 1'b0, 8'h08);
		for (int i = 0; i < 3; i++) begin
			prog.load(ACT_ADDR, 1'b0, 8'(i));
			rd_exp(1'b0, SIGS[8*i +: 8]);
		end
	endtask
	// Locks the arrays, tries a write, then erases and checks what survives.
	task automatic t_lock();
		prog.load(ACT_CMD, 1'b0, 8'h20);
		prog.load(ACT_DATA, 1'b0, 8'hfd);
		wr_exp(1'b0, 1'b1);
		prog.load(ACT_CMD, 1'b0, 8'h04);
		rd_exp(1'b1, 8'h7e);
		prog.load(ACT_CMD, 1'b0, 8'h11);
		prog.load(ACT_ADDR, 1'b0, 8'h80);
		prog.load(ACT_DATA, 1'b0, 8'h00);
		wr_exp(1'b0, 1'b1);
		prog.load(ACT_CMD, 1'b0, 8'h03);
		rd_exp(1'b0, 8'h3c);
		t_erase();
		prog.load(ACT_CMD, 1'b0, 8'h04);
		rd_exp(1'b1, 8'hfe);
		prog.load(ACT_CMD, 1'b0, 8'h03);
		rd_exp(1'b0, 8'hff);
	endtask
	// Main sequence after three reset cycles.
	initial begin
		repeat (3) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		t_entry();
		t_fuse();
		t_flash();
		t_eeprom();
		t_sig();
		t_lock();
		wrap_up();
	end
	// Watchdog at about six and a half times the expected run length.
	initial begin
		repeat (40000) @(posedge core_clk_i);
		n_fail++;
		wrap_up();
	end
endmodule // tb
